// ### e1_framer_control_port_tb.sv
// Self-checking testbench for the E1 framer control port
`timescale 1ns/1ps
`default_nettype none
module e1_framer_control_port_tb;
   import e1cp_pkg::*;
   logic ref_clk, rst, reset_pin_n, irq_req, irq_line, stream_chk;
   logic sp_sel, loc_top, rw, cs_n, ds_n, sysclk, fp_n, bus_en, irq_n_out, irq_oe, is_4m, ts_valid;
   logic [3:0] loc_low;
   logic [CH_W-1:0] ts_chan;
   logic [DATA_W-1:0] data_in, data_out, data_oe, bus_d, junk_q, ts_byte, rd, oe, wd;
   logic [DATA_W-1:0] mem [32];
   logic [31:0] z_q, o_q, st_seen;
   logic [4:0] a;
   int mismatches, samples_checked, npulse;

   // Wire levels: bus resolved from both parties, interrupt line pulled up
   assign data_in = (data_oe & data_out) | (~data_oe & (bus_en ? bus_d : junk_q));
   assign irq_line = irq_oe ? irq_n_out : 1'b1;

   e1cp_port dut (.ref_clk(ref_clk), .rst(rst), .reset_pin_n(reset_pin_n),
      .serial_parallel_select(sp_sel), .top_location_input(loc_top), .low_location_inputs(loc_low),
      .read_write(rw), .chip_select_n(cs_n), .data_strobe_n(ds_n), .system_clock_in(sysclk),
      .frame_pulse_in_n(fp_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
      .irq_req(irq_req), .irq_n_out(irq_n_out), .irq_oe(irq_oe), .sysclk_is_4m(is_4m),
      .ts_ctrl_valid(ts_valid), .ts_ctrl_chan(ts_chan), .ts_ctrl_byte(ts_byte));

   e1cp_host_model host (.ref_clk(ref_clk), .data_out(data_out), .data_oe(data_oe), .serial_parallel_select(sp_sel),
      .top_location_input(loc_top), .low_location_inputs(loc_low), .read_write(rw),
      .chip_select_n(cs_n), .data_strobe_n(ds_n), .system_clock_in(sysclk), .frame_pulse_in_n(fp_n),
      .bus_d(bus_d), .bus_en(bus_en), .junk_q(junk_q));

   // Expected interrupt line level and expected channel byte of a stream
   function automatic logic exp_irq(input logic req, input logic rstn);
      return !(req && rstn);
   endfunction
   function automatic logic [7:0] chan_byte(input logic [31:0] s, input int ch);
      return s[31-8*ch -: 8];
   endfunction

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_byte({7'h00, got}, {7'h00, exp});
   endtask

   task automatic conclude();
      $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Device reset pin held for the minimum time with a request pending
   task automatic pin_reset();
      irq_req = 1'b1;
      reset_pin_n = 1'b0;
      repeat (RESET_MIN_CYC) @(negedge ref_clk);
      chk_bit(irq_oe, 1'b0);
      chk_bit(ts_valid, 1'b0);
      reset_pin_n = 1'b1;
      repeat (6) @(negedge ref_clk);
      chk_bit(irq_line, exp_irq(irq_req, reset_pin_n));
   endtask

   // Each control stream one byte finished while stream_chk is set is checked against what was sent
   always @(negedge ref_clk) begin
      if (stream_chk && ts_valid === 1'b1) begin
         chk_byte({3'h0, ts_chan}, 8'(npulse));
         chk_byte(ts_byte, chan_byte(o_q, npulse));
         npulse++;
      end
   end

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // Watchdog well beyond the planned run length
   initial begin
      #200_000;
      mismatches++;
      conclude();
   end

   initial begin
      rst = 1'b1;
      reset_pin_n = 1'b1;
      irq_req = 1'b0;
      stream_chk = 1'b0;
      mismatches = 0;
      samples_checked = 0;
      npulse = 0;
      void'($urandom(32'h455b));
      repeat (12) @(negedge ref_clk);
      chk_byte(data_oe, 8'h00);
      chk_bit(irq_oe, 1'b0);
      rst = 1'b0;
      pin_reset();
      // Interrupt follows random requests while chip select stays high
      repeat (24) begin
         @(negedge ref_clk);
         irq_req = 1'($urandom);
         repeat (2) @(negedge ref_clk);
         chk_bit(irq_line, exp_irq(irq_req, reset_pin_n));
      end
      // Fill every location through the parallel bus, then read back at random
      for (int i = 0; i < 32; i++) begin
         mem[i] = 8'($urandom);
         host.par_access(1'b0, 1'b0, 5'(i), mem[i], rd, oe);
      end
      repeat (32) begin
         a = 5'($urandom);
         host.par_access(1'b0, 1'b1, a, 8'h00, rd, oe);
         chk_byte(rd, mem[a]);
         chk_byte(oe, PAR_OE);
         chk_byte(data_oe, 8'h00);
      end
      // Strobe with chip select high neither stores nor drives
      host.par_access(1'b1, 1'b0, 5'h1f, ~mem[31], rd, oe);
      host.par_access(1'b1, 1'b1, 5'h1f, 8'h00, rd, oe);
      chk_byte(rd, 8'h00);
      chk_byte(oe, 8'h00);
      host.par_access(1'b0, 1'b1, 5'h1f, 8'h00, rd, oe);
      chk_byte(rd, mem[31]);
      // Serial write and read back, alternating bit orders, cross-checked on the bus
      for (int m = 0; m < 4; m++) begin
         a = 5'($urandom);
         wd = 8'($urandom);
         mem[a] = wd;
         host.ser_access(m[0], 1'b0, a, wd, rd);
         host.ser_access(m[0], 1'b1, a, 8'h00, rd);
         chk_byte(rd, wd);
         chk_byte(data_oe, 8'h00);
         host.par_access(1'b0, 1'b1, a, 8'h00, rd, oe);
         chk_byte(rd, mem[a]);
      end
      // Backplane streams at both system clock rates
      host.stream_run(24, 32'h0000_0000, 32'h0000_0000, st_seen);
      chk_bit(is_4m, 1'b1);
      z_q = $urandom;
      o_q = $urandom;
      stream_chk = 1'b1;
      host.stream_run(49, z_q, o_q, st_seen);
      chk_bit(is_4m, 1'b0);
      // Status stream shows the old store; the fast run left zeros in channels zero and one
      for (int c = 0; c < 4; c++) begin
         chk_byte(chan_byte(st_seen, c), (c < 2) ? 8'h00 : mem[c]);
      end
      chk_byte(data_oe, STREAM_OE);
      repeat (4) @(negedge ref_clk);
      stream_chk = 1'b0;
      chk_byte(8'(npulse), 8'h04);
      for (int c = 0; c < 4; c++) begin
         host.par_access(1'b0, 1'b1, 5'(c), 8'h00, rd, oe);
         chk_byte(rd, chan_byte(z_q, c));
      end
      pin_reset();
      conclude();
   end
endmodule
`default_nettype wire

// ### e1cp_host_model.sv
// Host-side partner: parallel master, serial controller and backplane source
`timescale 1ns/1ps
`default_nettype none
module e1cp_host_model
   import e1cp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic [DATA_W-1:0] data_out,
   input wire logic [DATA_W-1:0] data_oe,
   output logic serial_parallel_select,
   output logic top_location_input,
   output logic [3:0] low_location_inputs,
   output logic read_write,
   output logic chip_select_n,
   output logic data_strobe_n,
   output logic system_clock_in,
   output logic frame_pulse_in_n,
   output logic [DATA_W-1:0] bus_d,
   output logic bus_en,
   output logic [DATA_W-1:0] junk_q
);
   // Idle pins; a released bus wanders every cycle instead of keeping its last value
   initial begin
      {serial_parallel_select, top_location_input, low_location_inputs} = 6'h00;
      {read_write, chip_select_n, data_strobe_n, frame_pulse_in_n} = 4'hf;
      system_clock_in = 1'b0;
      bus_d = 8'h00;
      bus_en = 1'b0;
      junk_q = 8'h00;
      forever @(negedge ref_clk) junk_q = {junk_q[6:0], ~junk_q[7]};
   end

   // One parallel access; address and data settle a cycle before the strobe
   task automatic par_access(input logic cs, input logic rd, input logic [4:0] a, input logic [7:0] wd,
         output logic [7:0] rdata, output logic [7:0] oe_seen);
      @(negedge ref_clk);
      {chip_select_n, data_strobe_n} = 2'h3;
      serial_parallel_select = 1'b0;
      {top_location_input, low_location_inputs} = a;
      read_write = rd;
      bus_d = wd;
      bus_en = !rd;
      @(negedge ref_clk);
      chip_select_n = cs;
      data_strobe_n = 1'b0;
      repeat (8) @(negedge ref_clk);
      rdata = data_out;
      oe_seen = data_oe;
      {chip_select_n, data_strobe_n} = 2'h3;
      repeat (2) @(negedge ref_clk);
      bus_en = 1'b0;
      repeat (4) @(negedge ref_clk);
   endtask

   // Serial transaction: command byte then data byte, clock idle level picks the order
   task automatic ser_access(input logic lsb, input logic rd, input logic [4:0] a, input logic [7:0] wd,
         output logic [7:0] rdata);
      logic [7:0] cmd;
      logic bv;
      int b;
      cmd = {rd, 2'($urandom), a};
      rdata = 8'h00;
      @(negedge ref_clk);
      chip_select_n = 1'b1;
      serial_parallel_select = 1'b1;
      top_location_input = 1'b0;
      data_strobe_n = lsb;
      repeat (6) @(negedge ref_clk);
      #1.3;
      chip_select_n = 1'b0;
      #32;
      for (int i = 0; i < 16; i++) begin
         b = lsb ? i % 8 : 7 - i % 8;
         bv = (i < 8) ? cmd[b] : wd[b];
         if (lsb) data_strobe_n = 1'b0;
         bus_en = lsb && !(rd && i >= 8);
         bus_d = {7'h00, bv};
         read_write = bv;
         #32;
         data_strobe_n = 1'b1;
         if (i >= 8) rdata[b] = data_out[0];
         #32;
         if (!lsb) data_strobe_n = 1'b0;
      end
      chip_select_n = 1'b1;
      bus_en = 1'b0;
      repeat (8) @(negedge ref_clk);
   endtask

   // Backplane frame: pulse, then 32 bits of both control streams, MSB first
   // Status bit of each enable is picked up just before the next system clock rise
   task automatic stream_run(input int half, input logic [31:0] z, input logic [31:0] o,
         output logic [31:0] seen);
      serial_parallel_select = 1'b1;
      top_location_input = 1'b1;
      seen = '0;
      for (int i = -2; i < 33; i++) begin
         repeat (half) @(negedge ref_clk);
         system_clock_in = 1'b0;
         frame_pulse_in_n = (i != -1);
         chip_select_n = 1'($urandom);
         read_write = (i >= 0 && i < 32) ? z[31-i] : 1'b0;
         data_strobe_n = (i >= 0 && i < 32) ? o[31-i] : 1'b0;
         repeat (half) @(negedge ref_clk);
         if (i >= 1 && i <= 32) seen[32-i] = data_out[0];
         system_clock_in = 1'b1;
      end
   endtask
endmodule
`default_nettype wire

// ### e1cp_mem.sv
// Small location store with registered read data
`timescale 1ns/1ps
`default_nettype none
module e1cp_mem #(
   parameter int AW = 5,
   parameter int DW = 8
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   typedef struct packed {
      logic [DW-1:0] rdata;
   } e1cp_mem_st_s;

   logic [DW-1:0] mem [2**AW];
   e1cp_mem_st_s st_q;
   e1cp_mem_st_s st_d;

   // Read port looks one cycle behind its address
   always_comb begin
      st_d.rdata = mem[raddr];
   end

   // Read data register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // Storage array, no reset so it maps onto plain memory
   always_ff @(posedge ref_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   assign rdata = st_q.rdata;
endmodule
`default_nettype wire

// ### e1cp_pkg.sv
// Shared constants and carrier types for the E1 framer control port
package e1cp_pkg;
   // Reference clock and pin timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int RESET_MIN_NS = 100;
   localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Period split between a 4.096 MHz (244 ns) and a 2.048 MHz (488 ns) system clock
   localparam int SYSCLK_SPLIT_NS = 366;
   localparam int SYSCLK_SPLIT_CYC = SYSCLK_SPLIT_NS / CLK_PERIOD_NS;
   localparam int PER_CNT_W = 7;
   localparam logic [PER_CNT_W-1:0] SYSCLK_SPLIT = PER_CNT_W'(SYSCLK_SPLIT_CYC);
   // Location store and byte layout
   localparam int ADDR_W = 5;
   localparam int DATA_W = 8;
   localparam int CH_W = 5;
   localparam int FRAME_BIT_W = 8;
   localparam int CMD_READ_POS = 7;
   // Serial transaction bit positions
   localparam logic [3:0] SER_LAST_CMD_BIT = 4'h7;
   localparam logic [3:0] SER_FIRST_DATA_BIT = 4'h8;
   localparam logic [3:0] SER_LAST_BIT = 4'hf;
   // Bit positions inside one backplane channel, and the stream and parallel read bus enables
   localparam logic [2:0] CH_FIRST_BIT = 3'h0;
   localparam logic [2:0] CH_LAST_BIT = 3'h7;
   localparam logic [DATA_W-1:0] STREAM_OE = 8'h01;
   localparam logic [DATA_W-1:0] PAR_OE = 8'hff;

   typedef enum logic [1:0] {MODE_PAR, MODE_SER, MODE_STREAM} e1cp_mode_e;
   typedef enum logic [1:0] {SER_IDLE, SER_CMD, SER_DATA} e1cp_sphase_e;

   // Data bus drive as seen at the pins
   typedef struct packed {
      logic [DATA_W-1:0] dout;
      logic [DATA_W-1:0] doe;
   } e1cp_bus_s;

   // Asynchronous pins after the synchroniser
   typedef struct packed {
      logic reset_n;
      logic ser_par_sel;
      logic loc_top;
      logic [3:0] loc_low;
      logic rw;
      logic cs_n;
      logic ds_n;
      logic sysclk;
      logic fp_n;
      logic [DATA_W-1:0] data;
   } e1cp_pins_s;
endpackage

// ### e1cp_port.sv
// Host control port: parallel bus, serial controller and backplane streams
`timescale 1ns/1ps
`default_nettype none
module e1cp_port
   import e1cp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic reset_pin_n,
   input wire logic serial_parallel_select,
   input wire logic top_location_input,
   input wire logic [3:0] low_location_inputs,
   input wire logic read_write,
   input wire logic chip_select_n,
   input wire logic data_strobe_n,
   input wire logic system_clock_in,
   input wire logic frame_pulse_in_n,
   input wire logic [DATA_W-1:0] data_in,
   output logic [DATA_W-1:0] data_out,
   output logic [DATA_W-1:0] data_oe,
   input wire logic irq_req,
   output logic irq_n_out,
   output logic irq_oe,
   output logic sysclk_is_4m,
   output logic ts_ctrl_valid,
   output logic [CH_W-1:0] ts_ctrl_chan,
   output logic [DATA_W-1:0] ts_ctrl_byte
);
   typedef struct packed {
      logic in_reset;
      logic cs_n_prev;
      logic sclk_prev;
      logic sysclk_prev;
      logic lsb_first;
      e1cp_sphase_e sph;
      logic [3:0] scnt;
      logic [DATA_W-1:0] sshift;
      logic [DATA_W-1:0] cmd;
      logic [DATA_W-1:0] sout;
      e1cp_bus_s bus;
      logic [PER_CNT_W-1:0] percnt;
      logic is4m;
      logic half;
      logic framed;
      logic [FRAME_BIT_W-1:0] bitcnt;
      logic [DATA_W-1:0] sh0;
      logic [DATA_W-1:0] sh1;
      logic [DATA_W-1:0] stat_sh;
      logic tsv;
      logic [CH_W-1:0] tsc;
      logic [DATA_W-1:0] tsb;
      logic irq_oe;
      logic irq_low;
   } e1cp_state_s;

   e1cp_state_s st_q;
   e1cp_state_s st_d;
   e1cp_pins_s pins;
   e1cp_mode_e mode;
   logic mem_we;
   logic [ADDR_W-1:0] mem_waddr;
   logic [DATA_W-1:0] mem_wdata;
   logic [ADDR_W-1:0] mem_raddr;
   logic [DATA_W-1:0] mem_rdata;
   logic active;
   logic cs_fall;
   logic sclk_rise;
   logic sclk_fall;
   logic sys_rise;
   logic bit_en;
   logic ser_bit;
   logic [DATA_W-1:0] ser_byte;
   logic [CH_W-1:0] chan;

   // Port personality from the two select pins
   function automatic e1cp_mode_e decode_mode(input logic sp_sel, input logic st_sel);
      if (!sp_sel) begin
         return MODE_PAR;
      end else if (st_sel) begin
         return MODE_STREAM;
      end
      return MODE_SER;
   endfunction

   // Every pin but irq_req crosses two flip-flops before use
   e1cp_sync #(
      .W($bits(e1cp_pins_s))
   ) u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .din({reset_pin_n, serial_parallel_select, top_location_input, low_location_inputs, read_write,
            chip_select_n, data_strobe_n, system_clock_in, frame_pulse_in_n, data_in}),
      .dout(pins)
   );

   // Location store shared by all three access modes
   e1cp_mem #(
      .AW(ADDR_W),
      .DW(DATA_W)
   ) u_mem (
      .ref_clk(ref_clk),
      .rst(rst),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(mem_wdata),
      .raddr(mem_raddr),
      .rdata(mem_rdata)
   );

   // Mode, edges and shared pin meanings
   assign mode = decode_mode(pins.ser_par_sel, pins.loc_top);
   assign active = ~pins.cs_n & ~pins.ds_n;
   assign cs_fall = st_q.cs_n_prev & ~pins.cs_n;
   assign sclk_rise = pins.ds_n & ~st_q.sclk_prev;
   assign sclk_fall = ~pins.ds_n & st_q.sclk_prev;
   assign sys_rise = pins.sysclk & ~st_q.sysclk_prev;
   assign bit_en = sys_rise & pins.fp_n & (~st_q.is4m | st_q.half);
   assign ser_bit = st_q.lsb_first ? pins.data[0] : pins.rw;
   assign ser_byte = st_q.lsb_first ? {ser_bit, st_q.sshift[DATA_W-1:1]} : {st_q.sshift[DATA_W-2:0], ser_bit};
   assign chan = st_q.bitcnt[FRAME_BIT_W-1:FRAME_BIT_W-CH_W];

   // Next state of the whole port
   always_comb begin
      st_d = st_q;
      mem_we = 1'b0;
      mem_waddr = '0;
      mem_wdata = '0;
      mem_raddr = '0;
      st_d.cs_n_prev = pins.cs_n;
      st_d.sclk_prev = pins.ds_n;
      st_d.sysclk_prev = pins.sysclk;
      st_d.in_reset = ~pins.reset_n;
      st_d.tsv = 1'b0;
      st_d.irq_low = 1'b0;
      st_d.irq_oe = irq_req & pins.reset_n;
      // System clock period measure and frame alignment
      if (sys_rise) begin
         st_d.is4m = st_q.percnt < SYSCLK_SPLIT;
         st_d.percnt = '0;
      end else if (st_q.percnt != '1) begin
         st_d.percnt = st_q.percnt + PER_CNT_W'(1);
      end
      if (sys_rise && !pins.fp_n) begin
         st_d.bitcnt = '0;
         st_d.half = 1'b0;
         st_d.framed = 1'b1;
      end else if (sys_rise && st_q.is4m) begin
         st_d.half = ~st_q.half;
      end
      if (bit_en && st_q.framed) begin
         st_d.bitcnt = st_q.bitcnt + 8'h01;
      end
      unique case (mode)
         MODE_PAR: begin
            st_d.sph = SER_IDLE;
            st_d.bus = '0;
            mem_raddr = {pins.loc_top, pins.loc_low};
            if (active && pins.rw) begin
               st_d.bus.dout = mem_rdata;
               st_d.bus.doe = PAR_OE;
            end
            if (active && !pins.rw) begin
               mem_we = 1'b1;
               mem_waddr = {pins.loc_top, pins.loc_low};
               mem_wdata = pins.data;
            end
         end
         MODE_SER: begin
            mem_raddr = st_q.cmd[ADDR_W-1:0];
            st_d.bus.dout[DATA_W-1:1] = '0;
            st_d.bus.doe[DATA_W-1:1] = '0;
            if (pins.cs_n) begin
               st_d.sph = SER_IDLE;
               st_d.bus = '0;
            end else if (cs_fall) begin
               st_d.lsb_first = pins.ds_n;
               st_d.sph = SER_CMD;
               st_d.scnt = '0;
               st_d.bus = '0;
            end else if (sclk_rise && st_q.sph != SER_IDLE) begin
               st_d.sshift = ser_byte;
               st_d.scnt = st_q.scnt + 4'h1;
               if (st_q.sph == SER_CMD && st_q.scnt == SER_LAST_CMD_BIT) begin
                  st_d.cmd = ser_byte;
                  st_d.sph = SER_DATA;
               end
               if (st_q.sph == SER_DATA && st_q.scnt == SER_LAST_BIT) begin
                  st_d.sph = SER_IDLE;
                  if (!st_q.cmd[CMD_READ_POS]) begin
                     mem_we = 1'b1;
                     mem_waddr = st_q.cmd[ADDR_W-1:0];
                     mem_wdata = ser_byte;
                  end
               end
            end else if (sclk_fall && st_q.sph == SER_DATA && st_q.cmd[CMD_READ_POS]) begin
               st_d.bus.doe[0] = 1'b1;
               if (st_q.scnt == SER_FIRST_DATA_BIT) begin
                  // First read bit comes straight from the store
                  st_d.bus.dout[0] = st_q.lsb_first ? mem_rdata[0] : mem_rdata[DATA_W-1];
                  st_d.sout = st_q.lsb_first ? {1'b0, mem_rdata[DATA_W-1:1]} : {mem_rdata[DATA_W-2:0], 1'b0};
               end else begin
                  st_d.bus.dout[0] = st_q.lsb_first ? st_q.sout[0] : st_q.sout[DATA_W-1];
                  st_d.sout = st_q.lsb_first ? {1'b0, st_q.sout[DATA_W-1:1]} : {st_q.sout[DATA_W-2:0], 1'b0};
               end
            end
         end
         MODE_STREAM: begin
            // Chip select plays no part here
            st_d.sph = SER_IDLE;
            mem_raddr = chan;
            st_d.bus.dout[DATA_W-1:1] = '0;
            st_d.bus.doe = st_q.framed ? STREAM_OE : '0;
            if (bit_en && st_q.framed) begin
               st_d.sh0 = {st_q.sh0[DATA_W-2:0], pins.rw};
               st_d.sh1 = {st_q.sh1[DATA_W-2:0], pins.ds_n};
               if (st_q.bitcnt[2:0] == CH_FIRST_BIT) begin
                  st_d.bus.dout[0] = mem_rdata[DATA_W-1];
                  st_d.stat_sh = {mem_rdata[DATA_W-2:0], 1'b0};
               end else begin
                  st_d.bus.dout[0] = st_q.stat_sh[DATA_W-1];
                  st_d.stat_sh = {st_q.stat_sh[DATA_W-2:0], 1'b0};
               end
               if (st_q.bitcnt[2:0] == CH_LAST_BIT) begin
                  mem_we = 1'b1;
                  mem_waddr = chan;
                  mem_wdata = {st_q.sh0[DATA_W-2:0], pins.rw};
                  st_d.tsv = 1'b1;
                  st_d.tsc = chan;
                  st_d.tsb = {st_q.sh1[DATA_W-2:0], pins.ds_n};
               end
            end
         end
      endcase
      // Reset pin low clears all port state but the edge history and sets in_reset; stored bytes are kept
      if (!pins.reset_n) begin
         st_d = '0;
         st_d.in_reset = 1'b1;
         st_d.cs_n_prev = pins.cs_n;
         st_d.sclk_prev = pins.ds_n;
         st_d.sysclk_prev = pins.sysclk;
         mem_we = 1'b0;
      end
   end

   // State register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs straight from the state register
   assign data_out = st_q.bus.dout;
   assign data_oe = st_q.bus.doe;
   assign irq_n_out = st_q.irq_low;
   assign irq_oe = st_q.irq_oe;
   assign sysclk_is_4m = st_q.is4m;
   assign ts_ctrl_valid = st_q.tsv;
   assign ts_ctrl_chan = st_q.tsc;
   assign ts_ctrl_byte = st_q.tsb;

   // Checks on the port behaviour
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   property p_reset_quiet;
      !pins.reset_n |=> (data_oe == 8'h00 && !irq_oe && !ts_ctrl_valid && st_q.in_reset);
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("Port active during reset");

   property p_irq_follow;
      (irq_req && pins.reset_n) [*2] |=> (irq_oe && !irq_n_out);
   endproperty
   a_irq_follow: assert property (p_irq_follow) else $error("Interrupt not pulled low");

   property p_par_read;
      (mode == MODE_PAR && active && pins.rw && pins.reset_n) |=> (data_oe == 8'hff && data_out == $past(mem_rdata));
   endproperty
   a_par_read: assert property (p_par_read) else $error("Parallel read not driven");

   property p_par_write;
      (mode == MODE_PAR && active && !pins.rw && pins.reset_n)
         |-> (mem_we && mem_waddr == {pins.loc_top, pins.loc_low} && mem_wdata == pins.data);
   endproperty
   a_par_write: assert property (p_par_write) else $error("Parallel write not stored");

   property p_par_rw_high;
      (mode == MODE_PAR && pins.rw) |-> !mem_we;
   endproperty
   a_par_rw_high: assert property (p_par_rw_high) else $error("Store written on a read");

   property p_cs_idle;
      (mode != MODE_STREAM && pins.cs_n) |=> (data_oe == 8'h00);
   endproperty
   a_cs_idle: assert property (p_cs_idle) else $error("Bus driven while deselected");

   property p_stream_drive;
      (mode == MODE_STREAM && st_q.framed && pins.reset_n) |=> (data_oe == 8'h01);
   endproperty
   a_stream_drive: assert property (p_stream_drive) else $error("Status stream not driven");

   property p_proto_pick;
      (mode == MODE_SER && cs_fall && pins.reset_n) |=> (st_q.lsb_first == $past(pins.ds_n) && st_q.sph == SER_CMD);
   endproperty
   a_proto_pick: assert property (p_proto_pick) else $error("Protocol not taken at select fall");

   property p_lsb_first_out;
      (mode == MODE_SER && sclk_fall && st_q.sph == SER_DATA && st_q.cmd[CMD_READ_POS] && st_q.lsb_first
         && st_q.scnt == SER_FIRST_DATA_BIT && !pins.cs_n && pins.reset_n)
         |=> (data_out[0] == $past(mem_rdata[0]) && data_oe[0]);
   endproperty
   a_lsb_first_out: assert property (p_lsb_first_out) else $error("First serial bit not LSB");

   property p_msb_only_bit0;
      (mode == MODE_SER) |=> (data_oe[DATA_W-1:1] == 7'h00);
   endproperty
   a_msb_only_bit0: assert property (p_msb_only_bit0) else $error("Serial mode drives upper bus");

   property p_msb_write;
      (mode == MODE_SER && sclk_rise && st_q.sph == SER_DATA && st_q.scnt == SER_LAST_BIT && !st_q.lsb_first
         && !st_q.cmd[CMD_READ_POS] && !pins.cs_n && pins.reset_n) |-> (mem_we && mem_wdata[0] == pins.rw);
   endproperty
   a_msb_write: assert property (p_msb_write) else $error("Receive pin bit not stored");

   property p_ctrl_take;
      (mode == MODE_STREAM && bit_en && st_q.framed && st_q.bitcnt[2:0] == CH_LAST_BIT && pins.reset_n)
         |-> (mem_we && mem_waddr == chan) ##1 (ts_ctrl_valid && ts_ctrl_chan == $past(chan));
   endproperty
   a_ctrl_take: assert property (p_ctrl_take) else $error("Control channel not taken");

   property p_frame_align;
      (sys_rise && !pins.fp_n && pins.reset_n) |=> (st_q.bitcnt == 8'h00 && st_q.framed);
   endproperty
   a_frame_align: assert property (p_frame_align) else $error("Frame pulse did not align");

   property p_rate_detect;
      (sys_rise && st_q.percnt < SYSCLK_SPLIT && pins.reset_n) |=> sysclk_is_4m;
   endproperty
   a_rate_detect: assert property (p_rate_detect) else $error("Fast system clock missed");
endmodule
`default_nettype wire

// ### e1cp_sync.sv
// Two-stage synchroniser for a bundle of asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module e1cp_sync #(
   parameter int W = 1
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } e1cp_sync_st_s;

   e1cp_sync_st_s st_q;
   e1cp_sync_st_s st_d;

   // First stage is read only by the second stage
   always_comb begin
      st_d.s1 = din;
      st_d.s2 = st_q.s1;
   end

   // State register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign dout = st_q.s2;
endmodule
`default_nettype wire
